//--- logic/tile_boot_loader.sv
// boot sequencer: reset hold, boot source choice, flash image load, checksum, pll setup
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps

module tile_boot_loader
	import tile_boot_pkg::*;
#(
	parameter int RAM_AW = 16,
	parameter int OTP_AW = 11,
	parameter logic [OTP_AW-1:0] SEC_OTP_ADDR = 11'h7ff
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rst_pin_n,
	output logic tile_reset_n,
	output logic gpio_pulldown_en,
	output logic otp_rd,
	output logic [OTP_AW-1:0] otp_addr,
	input wire logic otp_rvalid,
	input wire logic [31:0] otp_rdata,
	output logic ram_we,
	output logic [RAM_AW-1:0] ram_addr,
	output logic [31:0] ram_wdata,
	output logic exec_start,
	output logic exec_from_otp,
	output logic [RAM_AW-1:0] exec_addr,
	output logic boot_error,
	output logic [PLL_OD_W-1:0] pll_output_divider,
	output logic [PLL_F_W-1:0] pll_feedback,
	output logic [PLL_R_W-1:0] pll_ref_divider,
	input wire logic [AV_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic flash_clk,
	output logic flash_cs_n,
	input wire logic [3:0] flash_dq_in,
	output logic [3:0] flash_dq_out,
	output logic [3:0] flash_dq_oe
);

	// ====================================================================
	// functions
	function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b);
		logic [31:0] c;
		c = crc ^ {24'h000000, b};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ====================================================================
	// reset pin synchroniser
	logic pin_s1_reg;
	logic pin_s2_reg;

	always_ff @(posedge mclk)
	begin
		pin_s1_reg <= rst_pin_n;
		pin_s2_reg <= pin_s1_reg;
	end

	// ====================================================================
	// link domain: serial flash reader
	logic lk_rst_s1_reg;
	logic lk_rst_s2_reg;
	logic lk_go_s1_reg;
	logic lk_go_s2_reg;
	link_state_t lk_state_reg;
	logic [5:0] lk_cnt_reg;
	logic [31:0] lk_cmd_reg;
	logic [7:0] lk_shift_reg;
	logic [7:0] lk_byte_reg;
	logic lk_tgl_reg;
	logic lk_cs_n_reg;
	logic [3:0] lk_dq_out_reg;
	logic [3:0] lk_dq_oe_reg;
	logic boot_go_reg;

	wire lk_run = lk_rst_s2_reg & lk_go_s2_reg;
	wire [7:0] lk_shift_next = {lk_shift_reg[6:0], flash_dq_in[FLASH_DQ_IN]};
	wire lk_byte_done = (lk_state_reg == LK_DATA) && (lk_cnt_reg[2:0] == 3'h7);
	wire lk_cmd_done = (lk_state_reg == LK_CMD) && (lk_cnt_reg == 6'(FLASH_CMD_BITS - 1));

	always_ff @(posedge flash_clk)
	begin
		lk_rst_s1_reg <= nrst;
		lk_rst_s2_reg <= lk_rst_s1_reg;
		lk_go_s1_reg <= boot_go_reg;
		lk_go_s2_reg <= lk_go_s1_reg;
	end

	// single-lane read keeps the pin plan simple; dq2/dq3 stay undriven
	always_ff @(posedge flash_clk)
	begin
		if (!lk_run)
		begin
			lk_state_reg <= LK_IDLE;
			lk_cnt_reg <= 6'h00;
			lk_cs_n_reg <= 1'b1;
			lk_dq_oe_reg <= 4'h0;
			lk_dq_out_reg <= 4'h0;
			lk_cmd_reg <= {FLASH_READ_CMD, FLASH_IMAGE_ADDR};
			lk_tgl_reg <= 1'b0;
		end
		else
		begin
			case (lk_state_reg)
				LK_IDLE:
				begin
					lk_state_reg <= LK_CMD;
					lk_cs_n_reg <= 1'b0;
					lk_dq_oe_reg <= 4'h1 << FLASH_DQ_OUT;
					lk_dq_out_reg <= {3'h0, lk_cmd_reg[31]} << FLASH_DQ_OUT;
					lk_cmd_reg <= {lk_cmd_reg[30:0], 1'b0};
				end
				LK_CMD:
				begin
					lk_cnt_reg <= lk_cmd_done ? 6'h00 : lk_cnt_reg + 6'h01;
					lk_dq_out_reg <= {3'h0, lk_cmd_reg[31]} << FLASH_DQ_OUT;
					lk_cmd_reg <= {lk_cmd_reg[30:0], 1'b0};
					if (lk_cmd_done)
					begin
						lk_state_reg <= LK_DATA;
						lk_dq_oe_reg <= 4'h0;
					end
				end
				LK_DATA:
				begin
					lk_cnt_reg <= lk_cnt_reg + 6'h01;
					lk_shift_reg <= lk_shift_next;
					if (lk_byte_done)
					begin
						lk_byte_reg <= lk_shift_next;
						lk_tgl_reg <= ~lk_tgl_reg;
					end
				end
				default:
				begin
					lk_state_reg <= LK_IDLE;
				end
			endcase
		end
	end

	assign flash_cs_n = lk_cs_n_reg;
	assign flash_dq_out = lk_dq_out_reg;
	assign flash_dq_oe = lk_dq_oe_reg;

	// ====================================================================
	// byte event crossing into mclk
	logic tg_s1_reg;
	logic tg_s2_reg;
	logic tg_s3_reg;

	always_ff @(posedge mclk)
	begin
		tg_s1_reg <= lk_tgl_reg;
		tg_s2_reg <= tg_s1_reg;
		tg_s3_reg <= tg_s2_reg;
	end

	// held byte is stable for eight link clocks after the toggle, far longer than the sync
	wire byte_evt = tg_s2_reg ^ tg_s3_reg;
	wire [7:0] rx_byte = lk_byte_reg;

	// ====================================================================
	// boot sequencer
	boot_state_t state_reg;
	boot_state_t state_next;
	logic [INTRST_CW-1:0] delay_reg;
	logic [1:0] bidx_reg;
	logic [31:0] asm_reg;
	logic [31:0] length_reg;
	logic [31:0] wcnt_reg;
	logic [31:0] crc_reg;
	logic [31:0] stored_crc_reg;
	logic sec_boot_reg;
	logic otp_rd_reg;
	logic ram_we_reg;
	logic [RAM_AW-1:0] ram_addr_reg;
	logic [31:0] ram_wdata_reg;
	logic exec_start_reg;
	logic error_reg;

	wire [31:0] asm_next = {rx_byte, asm_reg[31:8]};
	wire word_done = byte_evt && (bidx_reg == LAST_BYTE);
	wire len_zero = (asm_next == 32'h0);
	wire len_big = (asm_next > 32'(1 << RAM_AW));
	wire prog_last = word_done && (wcnt_reg + 32'h1 == length_reg);
	wire crc_ok = (stored_crc_reg == CRC_SKIP_WORD) || (stored_crc_reg == ~crc_reg);
	wire in_load = (state_reg == ST_LEN) || (state_reg == ST_PROG) || (state_reg == ST_CRC);
	wire crc_feed = byte_evt && ((state_reg == ST_LEN) || (state_reg == ST_PROG));

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
			begin
				state_next = ST_INTRST;
			end
			ST_INTRST:
			begin
				if (delay_reg == INTRST_CW'(INTRST_CYCLES - 1))
				begin
					state_next = ST_SECRD;
				end
			end
			ST_SECRD:
			begin
				state_next = ST_SECWAIT;
			end
			ST_SECWAIT:
			begin
				if (otp_rvalid)
				begin
					state_next = otp_rdata[SEC_BOOT_BIT] ? ST_START : ST_LEN;
				end
			end
			ST_LEN:
			begin
				if (word_done)
				begin
					state_next = len_big ? ST_FAIL : (len_zero ? ST_CRC : ST_PROG);
				end
			end
			ST_PROG:
			begin
				if (prog_last)
				begin
					state_next = ST_CRC;
				end
			end
			ST_CRC:
			begin
				if (word_done)
				begin
					state_next = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				state_next = crc_ok ? ST_START : ST_FAIL;
			end
			ST_START:
			begin
				state_next = ST_RUN;
			end
			ST_RUN:
			begin
				state_next = ST_RUN;
			end
			ST_FAIL:
			begin
				state_next = ST_FAIL;
			end
			default:
			begin
				state_next = ST_RESET;
			end
		endcase
	end

	// a low pin restarts the sequencer state and its load registers, whatever the sequencer was doing; output, pll and bus registers wait for nrst
	always_ff @(posedge mclk)
	begin
		if (!nrst || !pin_s2_reg)
		begin
			state_reg <= ST_RESET;
			delay_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			delay_reg <= (state_reg == ST_INTRST) ? delay_reg + INTRST_CW'(1) : '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst || !pin_s2_reg)
		begin
			bidx_reg <= 2'h0;
			asm_reg <= 32'h0;
			length_reg <= 32'h0;
			wcnt_reg <= 32'h0;
			crc_reg <= CRC_INIT;
			stored_crc_reg <= 32'h0;
			sec_boot_reg <= 1'b0;
		end
		else
		begin
			if (in_load && byte_evt)
			begin
				bidx_reg <= bidx_reg + 2'h1;
				asm_reg <= asm_next;
			end
			if (crc_feed)
			begin
				crc_reg <= crc_byte(crc_reg, rx_byte);
			end
			if (state_reg == ST_LEN && word_done)
			begin
				length_reg <= asm_next;
			end
			if (state_reg == ST_PROG && word_done)
			begin
				wcnt_reg <= wcnt_reg + 32'h1;
			end
			if (state_reg == ST_CRC && word_done)
			begin
				stored_crc_reg <= asm_next;
			end
			if (state_reg == ST_SECWAIT && otp_rvalid)
			begin
				sec_boot_reg <= otp_rdata[SEC_BOOT_BIT];
			end
		end
	end

	// ====================================================================
	// outputs of the sequencer
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			boot_go_reg <= 1'b0;
			otp_rd_reg <= 1'b0;
			ram_we_reg <= 1'b0;
			ram_addr_reg <= '0;
			ram_wdata_reg <= 32'h0;
			exec_start_reg <= 1'b0;
			error_reg <= 1'b0;
			tile_reset_n <= 1'b0;
			gpio_pulldown_en <= 1'b1;
		end
		else
		begin
			boot_go_reg <= in_load && (state_next != ST_CHECK) && (state_next != ST_FAIL);
			otp_rd_reg <= (state_reg == ST_SECRD);
			ram_we_reg <= (state_reg == ST_PROG) && word_done;
			if ((state_reg == ST_PROG) && word_done)
			begin
				ram_addr_reg <= wcnt_reg[RAM_AW-1:0];
				ram_wdata_reg <= asm_next;
			end
			exec_start_reg <= (state_reg == ST_START);
			error_reg <= (state_reg == ST_FAIL);
			tile_reset_n <= pin_s2_reg && (state_reg != ST_RESET) && (state_reg != ST_INTRST);
			gpio_pulldown_en <= !pin_s2_reg;
		end
	end

	assign otp_rd = otp_rd_reg;
	assign otp_addr = SEC_OTP_ADDR;
	assign ram_we = ram_we_reg;
	assign ram_addr = ram_addr_reg;
	assign ram_wdata = ram_wdata_reg;
	assign exec_start = exec_start_reg;
	assign exec_from_otp = sec_boot_reg;
	assign exec_addr = '0;
	assign boot_error = error_reg;

	// ====================================================================
	// register slave
	logic [PLL_F_W-1:0] pll_f_reg;
	logic [PLL_R_W-1:0] pll_r_reg;
	logic [PLL_OD_W-1:0] pll_od_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;

	wire av_req = avs_read | avs_write;
	wire av_wr = avs_write && !wait_reg;
	wire [31:0] pll_word = (32'(pll_f_reg) << PLL_F_LSB) | (32'(pll_r_reg) << PLL_R_LSB)
		| (32'(pll_od_reg) << PLL_OD_LSB);
	wire [31:0] pll_merged = merge_be(pll_word, avs_writedata, avs_byteenable);
	wire [31:0] status_word = (32'(state_reg) << STAT_STATE_LSB)
		| (32'(sec_boot_reg) << STAT_OTP_BIT)
		| (32'(state_reg == ST_RUN) << STAT_DONE_BIT)
		| (32'(error_reg) << STAT_ERR_BIT);
	wire [31:0] rd_mux = (avs_address == REG_PLL_CFG) ? pll_word :
		(avs_address == REG_STATUS) ? status_word :
		(avs_address == REG_CRC) ? ~crc_reg :
		(avs_address == REG_LENGTH) ? length_reg : 32'h0;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			pll_f_reg <= PLL_F_RST;
			pll_r_reg <= PLL_R_RST;
			pll_od_reg <= PLL_OD_RST;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0;
		end
		else
		begin
			wait_reg <= !(av_req && wait_reg);
			if (avs_read && wait_reg)
			begin
				rdata_reg <= rd_mux;
			end
			if (av_wr && avs_address == REG_PLL_CFG)
			begin
				pll_f_reg <= pll_merged[PLL_F_LSB +: PLL_F_W];
				pll_r_reg <= pll_merged[PLL_R_LSB +: PLL_R_W];
				pll_od_reg <= pll_merged[PLL_OD_LSB +: PLL_OD_W];
			end
		end
	end

	// range limits on these fields are left to software
	assign pll_feedback = pll_f_reg;
	assign pll_ref_divider = pll_r_reg;
	assign pll_output_divider = pll_od_reg;
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;

endmodule

//--- common/tile_boot_pkg.sv
// constants, register map and state codes for the tile boot loader
package tile_boot_pkg;

	// ====================================================================
	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int INTRST_MIN_US = 15;
	localparam int INTRST_CYCLES = (INTRST_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INTRST_CW = $clog2(INTRST_CYCLES + 1);

	// ====================================================================
	// image format and checksum
	localparam logic [31:0] CRC_SKIP_WORD = 32'h0d15ab1e;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// ====================================================================
	// security word and flash command
	localparam int SEC_BOOT_BIT = 5;
	localparam logic [7:0] FLASH_READ_CMD = 8'h03;
	localparam logic [23:0] FLASH_IMAGE_ADDR = 24'h000000;
	localparam int FLASH_CMD_BITS = 32;
	localparam int FLASH_DQ_OUT = 0;
	localparam int FLASH_DQ_IN = 1;

	// ====================================================================
	// pll configuration register
	localparam int PLL_F_W = 12;
	localparam int PLL_R_W = 6;
	localparam int PLL_OD_W = 3;
	localparam int PLL_F_LSB = 0;
	localparam int PLL_R_LSB = 16;
	localparam int PLL_OD_LSB = 24;
	localparam logic [PLL_F_W-1:0] PLL_F_RST = 12'h03f;
	localparam logic [PLL_R_W-1:0] PLL_R_RST = 6'h00;
	localparam logic [PLL_OD_W-1:0] PLL_OD_RST = 3'h1;

	// ====================================================================
	// register map, byte addresses
	localparam int AV_AW = 4;
	localparam logic [AV_AW-1:0] REG_PLL_CFG = 4'h0;
	localparam logic [AV_AW-1:0] REG_STATUS = 4'h4;
	localparam logic [AV_AW-1:0] REG_CRC = 4'h8;
	localparam logic [AV_AW-1:0] REG_LENGTH = 4'hc;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_OTP_BIT = 8;
	localparam int STAT_DONE_BIT = 9;
	localparam int STAT_ERR_BIT = 10;

	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_INTRST = 4'h1,
		ST_SECRD = 4'h2,
		ST_SECWAIT = 4'h3,
		ST_LEN = 4'h4,
		ST_PROG = 4'h5,
		ST_CRC = 4'h6,
		ST_CHECK = 4'h7,
		ST_START = 4'h8,
		ST_RUN = 4'h9,
		ST_FAIL = 4'ha
	} boot_state_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'h0,
		LK_CMD = 2'h1,
		LK_DATA = 2'h2
	} link_state_t;

endpackage

//--- sim/tile_boot_loader_chk.sv
// port checks for the tile boot loader
`timescale 1ns/1ps
module tile_boot_chk
	import tile_boot_pkg::*;
#(
	parameter int RAM_AW = 16
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rst_pin_n,
	input wire logic tile_reset_n,
	input wire logic gpio_pulldown_en,
	input wire logic otp_rvalid,
	input wire logic [31:0] otp_rdata,
	input wire logic ram_we,
	input wire logic [RAM_AW-1:0] ram_addr,
	input wire logic exec_start,
	input wire logic exec_from_otp,
	input wire logic [RAM_AW-1:0] exec_addr,
	input wire logic boot_error,
	input wire logic [PLL_OD_W-1:0] pll_output_divider,
	input wire logic [PLL_F_W-1:0] pll_feedback,
	input wire logic [PLL_R_W-1:0] pll_ref_divider,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	// ====================================================================
	// helpers: cycles since pin release, words written so far
	logic [15:0] held;
	logic [RAM_AW-1:0] wcnt;
	always_ff @(posedge mclk)
		if (!nrst || !rst_pin_n)
			held <= '0;
		else if (!tile_reset_n && held != '1)
			held <= held + 16'h1;
	always_ff @(posedge mclk)
		if (!nrst || !tile_reset_n)
			wcnt <= '0;
		else if (ram_we)
			wcnt <= wcnt + 1'b1;
	// ====================================================================
	// assertions
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	a_hold_reset: assert property ((!rst_pin_n) [*6] |-> !tile_reset_n)
		else $error("tile out of reset while pin low");
	a_pulldown_on: assert property ((!rst_pin_n) [*6] |-> gpio_pulldown_en)
		else $error("pull-downs off while pin low");
	a_intrst_delay: assert property ($rose(tile_reset_n) |->
		held >= INTRST_CYCLES && held <= INTRST_CYCLES * 10)
		else $error("internal reset delay out of range");
	a_exec_zero: assert property (exec_start |-> exec_addr == '0)
		else $error("start address not zero");
	a_ram_order: assert property (ram_we |-> ram_addr == wcnt)
		else $error("ram word out of order");
	a_err_no_start: assert property (boot_error |-> !exec_start)
		else $error("start after checksum failure");
	a_pll_boot: assert property ($rose(nrst) |-> pll_output_divider == PLL_OD_RST
		&& pll_feedback == PLL_F_RST && pll_ref_divider == PLL_R_RST)
		else $error("pll boot settings wrong");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
	a_otp_source: assert property (otp_rvalid && otp_rdata[SEC_BOOT_BIT]
		|-> ##[1:256] exec_start && exec_from_otp)
		else $error("secure boot did not start from otp");
endmodule

bind tile_boot_loader tile_boot_chk #(.RAM_AW(RAM_AW)) chk_u (.mclk, .nrst, .rst_pin_n,
	.tile_reset_n, .gpio_pulldown_en, .otp_rvalid, .otp_rdata, .ram_we, .ram_addr,
	.exec_start, .exec_from_otp, .exec_addr, .boot_error, .pll_output_divider,
	.pll_feedback, .pll_ref_divider, .avs_read, .avs_write, .avs_waitrequest);

//--- sim/boot_flash_model.sv
// boot flash model: read command on dq0, image bytes msb first on dq1
`timescale 1ns/1ps
module boot_flash_model (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] dq_out,
	input wire logic [3:0] dq_oe,
	output logic [3:0] dq_in
);
	logic [7:0] img [0:31];
	logic [31:0] cmd = 32'h0;
	logic noise = 1'b0;
	logic dbit = 1'b0;
	int bits = 0;
	int frames = 0;
	initial
		foreach (img[i])
			img[i] = 8'h00;
	// ====================================================================
	// undriven lines wander so a stale level never passes for data
	assign dq_in = {noise, noise, dbit, dq_oe[0] ? dq_out[0] : noise};
	always @(posedge sck or posedge cs_n)
		if (cs_n)
			bits <= 0;
		else
		begin
			if (bits < 32)
				cmd <= {cmd[30:0], dq_in[0]};
			if (bits == 0)
				frames <= frames + 1;
			bits <= bits + 1;
		end
	always @(negedge sck)
	begin
		noise <= !noise;
		if (!cs_n && bits >= 32 && bits < 288)
			dbit <= img[(bits - 32) / 8][7 - (bits - 32) % 8];
		else
			dbit <= !noise;
	end
endmodule

//--- sim/tb_top.sv
// bench: register access, then otp and flash boots
`timescale 1ns/1ps
module tb_top;
	import tile_boot_pkg::*;
	logic mclk = 1'b0;
	logic flash_clk = 1'b0;
	logic nrst = 1'b0;
	logic rst_pin_n = 1'b0;
	logic otp_rvalid = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] otp_rdata = 32'h0;
	logic tile_reset_n, gpio_pulldown_en, otp_rd, ram_we, exec_start, exec_from_otp;
	logic boot_error, avs_waitrequest, flash_cs_n;
	logic [10:0] otp_addr;
	logic [15:0] ram_addr, exec_addr;
	logic [31:0] ram_wdata, avs_readdata, q, pll_v;
	logic [31:0] rnd = 32'hefb04c2b;
	logic [2:0] pll_output_divider;
	logic [11:0] pll_feedback;
	logic [5:0] pll_ref_divider;
	logic [3:0] flash_dq_in, flash_dq_out, flash_dq_oe, be;
	logic [63:0] rd_q[$], ram_q[$], end_q[$];
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;

	tile_boot_loader dut_u (.mclk(mclk), .nrst(nrst), .rst_pin_n(rst_pin_n),
		.tile_reset_n(tile_reset_n), .gpio_pulldown_en(gpio_pulldown_en), .otp_rd(otp_rd),
		.otp_addr(otp_addr), .otp_rvalid(otp_rvalid), .otp_rdata(otp_rdata), .ram_we(ram_we),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .exec_start(exec_start),
		.exec_from_otp(exec_from_otp), .exec_addr(exec_addr), .boot_error(boot_error),
		.pll_output_divider(pll_output_divider), .pll_feedback(pll_feedback),
		.pll_ref_divider(pll_ref_divider), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_clk(flash_clk),
		.flash_cs_n(flash_cs_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe));
	boot_flash_model fl_u (.sck(flash_clk), .cs_n(flash_cs_n), .dq_out(flash_dq_out),
		.dq_oe(flash_dq_oe), .dq_in(flash_dq_in));

	initial
		forever #2 mclk = !mclk;
	// link logic runs on this clock, so it runs free
	initial
	begin
		#13;
		forever #40 flash_clk = !flash_clk;
	end

	// ====================================================================
	// helpers
	function automatic logic [31:0] nx();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction
	function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
		c = c ^ {24'h0, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	function automatic logic [31:0] fld(input logic [31:0] v);
		fld = '0;
		fld[PLL_F_LSB +: PLL_F_W] = v[PLL_F_LSB +: PLL_F_W];
		fld[PLL_R_LSB +: PLL_R_W] = v[PLL_R_LSB +: PLL_R_W];
		fld[PLL_OD_LSB +: PLL_OD_W] = v[PLL_OD_LSB +: PLL_OD_W];
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		avs_byteenable <= b;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	// ====================================================================
	// one boot: sec picks otp; mode 0 good checksum, 1 skip word, 2 bad checksum
	task automatic boot(input logic sec, input int s, input int mode);
		logic [7:0] b[$];
		logic [31:0] c;
		logic [31:0] w;
		int n;
		int f0;
		c = CRC_INIT;
		for (int i = 0; i < 4; i++)
			b.push_back(8'(s >> 8 * i));
		for (int i = 0; i < s; i++)
		begin
			w = nx();
			if (!sec)
				ram_q.push_back({16'h0, 16'(i), w});
			for (int k = 0; k < 4; k++)
				b.push_back(w[8 * k +: 8]);
		end
		foreach (b[i])
			c = crc8(c, b[i]);
		c = ~c;
		if (mode == 1)
			c = CRC_SKIP_WORD;
		if (mode == 2)
		begin
			w = nx();
			c = c ^ (32'h1 << w[4:0]);
		end
		for (int i = 0; i < 4; i++)
			b.push_back(c[8 * i +: 8]);
		foreach (b[i])
			fl_u.img[i] = b[i];
		end_q.push_back({sec, mode != 2, mode == 2});
		f0 = fl_u.frames;
		rst_pin_n <= 1'b0;
		repeat (6) @(posedge mclk);
		chk({tile_reset_n, gpio_pulldown_en}, 2'b01);
		rst_pin_n <= 1'b1;
		n = 0;
		while (otp_rd !== 1'b1)
		begin
			@(posedge mclk);
			n++;
		end
		chk(n >= INTRST_CYCLES, 1);
		chk(otp_addr, 11'h7ff);
		w = nx();
		repeat (w[2:0]) @(posedge mclk);
		otp_rdata <= {w[31:6], sec, w[4:0]};
		otp_rvalid <= 1'b1;
		@(posedge mclk);
		otp_rvalid <= 1'b0;
		otp_rdata <= ~w;
		while (exec_start !== 1'b1 && boot_error !== 1'b1)
			@(posedge mclk);
		@(posedge mclk);
		chk(ram_q.size(), 0);
		chk(fl_u.frames - f0, !sec);
		if (!sec)
			chk(fl_u.cmd, {FLASH_READ_CMD, FLASH_IMAGE_ADDR});
		if (!sec && mode == 0)
		begin
			rd_q.push_back(64'(s));
			bus(1'b0, REG_LENGTH, 32'h0, 4'hf);
		end
	endtask

	// ====================================================================
	// result watcher
	always @(posedge mclk)
		if (nrst === 1'b1)
		begin
			if (ram_we === 1'b1)
				chk({ram_addr, ram_wdata}, ram_q.size() ? ram_q.pop_front() : '1);
			if (exec_start === 1'b1 || $rose(boot_error))
				chk({exec_from_otp, exec_start, boot_error}, end_q.size() ? end_q.pop_front() : '1);
			if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
				chk(avs_readdata, rd_q.size() ? rd_q.pop_front() : '1);
		end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 50000)
		begin
			n_fail++;
			summarize;
		end
	end

	// ====================================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		rst_pin_n <= 1'b1;
		pll_v = fld({5'h0, PLL_OD_RST, 2'h0, PLL_R_RST, 4'h0, PLL_F_RST});
		rd_q.push_back(pll_v);
		bus(1'b0, REG_PLL_CFG, 32'h0, 4'hf);
		rd_q.push_back(64'h0);
		bus(1'b0, 4'h2, 32'h0, 4'hf);
		boot(1'b1, 0, 0);
		boot(1'b0, 3, 0);
		boot(1'b0, 2, 1);
		boot(1'b0, 1, 2);
		boot(1'b0, 0, 0);
		// pll is reprogrammed here after the boots, though the slave takes writes in any state; field widths bound each range
		for (int i = 0; i < 4; i++)
		begin
			q = nx();
			be = i ? q[7:4] : 4'hf;
			bus(1'b1, REG_PLL_CFG, q, be);
			for (int k = 0; k < 4; k++)
				if (be[k])
					pll_v[8 * k +: 8] = q[8 * k +: 8];
			pll_v = fld(pll_v);
			chk({pll_output_divider, pll_ref_divider, pll_feedback}, {pll_v[PLL_OD_LSB +: PLL_OD_W],
				pll_v[PLL_R_LSB +: PLL_R_W], pll_v[PLL_F_LSB +: PLL_F_W]});
			rd_q.push_back(pll_v);
			bus(1'b0, REG_PLL_CFG, 32'h0, 4'hf);
		end
		summarize;
	end
endmodule
